// file: design/amd_params.svh
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

`define AMD_PRE_SEC_IDX     8'h90
`define AMD_PRE_IND_SEC     8'h91
`define AMD_PRE_IND_PRI     8'h92
`define AMD_PAGE0_MASK      16'h00FF
`define AMD_ZERO_HI         8'h00
`define AMD_ONE_BYTE        3'h1
`define AMD_TWO_BYTES       3'h2
`define AMD_MAX_LEN         3'h4
`define AMD_OPCODE_COUNT    63
`define AMD_GROUP_COUNT     13
`define AMD_SP_RESET        16'h01FF

`endif

// file: design/amd_pkg.sv
package amd_pkg;

    typedef enum logic [3:0] {
        AMD_MODE_INH  = 4'h0,
        AMD_MODE_IMM  = 4'h1,
        AMD_MODE_DIRS = 4'h2,
        AMD_MODE_DIRL = 4'h3,
        AMD_MODE_IX0  = 4'h4,
        AMD_MODE_IXS  = 4'h5,
        AMD_MODE_IXL  = 4'h6,
        AMD_MODE_INDS = 4'h7,
        AMD_MODE_INDL = 4'h8,
        AMD_MODE_IIXS = 4'h9,
        AMD_MODE_IIXL = 4'hA,
        AMD_MODE_RELD = 4'hB,
        AMD_MODE_RELI = 4'hC,
        AMD_MODE_ILL  = 4'hF
    } amd_mode_t;

    typedef enum logic [2:0] {
        AMD_CLS_NONE = 3'h0,
        AMD_CLS_ALU  = 3'h1,
        AMD_CLS_RMW  = 3'h2,
        AMD_CLS_JMP  = 3'h3,
        AMD_CLS_REL  = 3'h4
    } amd_cls_t;

    typedef enum logic [7:0] {
        AMD_ST_IDLE = 8'h01,
        AMD_ST_OPC  = 8'h02,
        AMD_ST_OP1  = 8'h04,
        AMD_ST_OP2  = 8'h08,
        AMD_ST_PTR  = 8'h10,
        AMD_ST_PTRL = 8'h20,
        AMD_ST_DONE = 8'h40,
        AMD_ST_ILL  = 8'h80
    } amd_state_t;

endpackage : amd_pkg

// file: design/amd_opcode_class.sv
`timescale 1ns/100ps
`default_nettype none
`include "amd_params.svh"

module amd_opcode_class (
    input  wire logic [7:0]        opcode,
    input  wire logic              pre_ind,
    output var  amd_pkg::amd_mode_t mode,
    output var  amd_pkg::amd_cls_t  cls,
    output var  logic              legal
);
    logic [3:0] hi;
    logic [3:0] lo;
    logic       alu_lo;
    logic       rmw_lo;

    assign hi     = opcode[7:4];
    assign lo     = opcode[3:0];
    // alu group: load, compare, logic, add/subtract and bit compare; jump and call (low nibbles D and C) fall outside it
    assign alu_lo = (lo != 4'hD) && (lo != 4'hC);
    assign rmw_lo = (lo != 4'h1) && (lo != 4'h2) && (lo != 4'h5) && (lo != 4'hB);

    // =====================================================
    // opcode row decode
    always_comb begin
        mode  = amd_pkg::AMD_MODE_ILL;
        cls   = amd_pkg::AMD_CLS_NONE;
        legal = 1'b0;
        case (hi)
            4'h0, 4'h1: begin
                // bit test/branch and bit set/reset use short direct (or indirect with prefix)
                mode  = pre_ind ? amd_pkg::AMD_MODE_INDS : amd_pkg::AMD_MODE_DIRS;
                cls   = amd_pkg::AMD_CLS_RMW;
                legal = 1'b1;
            end
            4'h2: begin
                mode  = pre_ind ? amd_pkg::AMD_MODE_RELI : amd_pkg::AMD_MODE_RELD;
                cls   = amd_pkg::AMD_CLS_REL;
                legal = 1'b1;
            end
            4'h3, 4'h6, 4'h7: begin
                // rmw ops: short forms only
                if (rmw_lo) begin
                    legal = 1'b1;
                    cls   = amd_pkg::AMD_CLS_RMW;
                    if (hi == 4'h3) begin
                        mode = pre_ind ? amd_pkg::AMD_MODE_INDS : amd_pkg::AMD_MODE_DIRS;
                    end else if (hi == 4'h6) begin
                        mode = pre_ind ? amd_pkg::AMD_MODE_IIXS : amd_pkg::AMD_MODE_IXS;
                    end else begin
                        mode = amd_pkg::AMD_MODE_IX0;
                    end
                end
            end
            4'h4, 4'h5, 4'h8, 4'h9: begin
                mode  = amd_pkg::AMD_MODE_INH;
                legal = 1'b1;
            end
            4'hA: begin
                mode  = (lo == 4'hD) ? amd_pkg::AMD_MODE_RELD : amd_pkg::AMD_MODE_IMM;
                cls   = (lo == 4'hD) ? amd_pkg::AMD_CLS_REL : amd_pkg::AMD_CLS_ALU;
                legal = (lo != 4'hC);
            end
            4'hB: begin
                mode  = pre_ind ? amd_pkg::AMD_MODE_INDS : amd_pkg::AMD_MODE_DIRS;
                cls   = alu_lo ? amd_pkg::AMD_CLS_ALU : amd_pkg::AMD_CLS_JMP;
                legal = 1'b1;
            end
            4'hC: begin
                mode  = pre_ind ? amd_pkg::AMD_MODE_INDL : amd_pkg::AMD_MODE_DIRL;
                cls   = alu_lo ? amd_pkg::AMD_CLS_ALU : amd_pkg::AMD_CLS_JMP;
                legal = 1'b1;
            end
            4'hD: begin
                mode  = pre_ind ? amd_pkg::AMD_MODE_IIXL : amd_pkg::AMD_MODE_IXL;
                cls   = alu_lo ? amd_pkg::AMD_CLS_ALU : amd_pkg::AMD_CLS_JMP;
                legal = 1'b1;
            end
            4'hE: begin
                mode  = pre_ind ? amd_pkg::AMD_MODE_IIXS : amd_pkg::AMD_MODE_IXS;
                cls   = alu_lo ? amd_pkg::AMD_CLS_ALU : amd_pkg::AMD_CLS_JMP;
                legal = 1'b1;
            end
            default: begin
                mode  = amd_pkg::AMD_MODE_IX0;
                cls   = alu_lo ? amd_pkg::AMD_CLS_ALU : amd_pkg::AMD_CLS_JMP;
                legal = 1'b1;
            end
        endcase
    end
endmodule : amd_opcode_class
`default_nettype wire

// file: design/amd_decoder.sv
`timescale 1ns/100ps
`default_nettype none
`include "amd_params.svh"

module amd_decoder #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic              start,
    input  wire logic [ADDR_W-1:0] pc_in,
    input  wire logic [7:0]        idx_pri,
    input  wire logic [7:0]        idx_sec,
    input  wire logic [7:0]        mem_rdata,
    input  wire logic              mem_rvalid,
    output logic                   mem_req,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [ADDR_W-1:0]      ea_addr,
    output logic [ADDR_W-1:0]      pc_next,
    output logic                   ea_valid,
    output logic                   use_sec,
    output logic [7:0]             opcode_out,
    output logic [2:0]             instr_len,
    output logic                   illegal_rst,
    output logic                   done
);
    // =====================================================
    // state and registers
    amd_pkg::amd_state_t st_q, st_d;
    amd_pkg::amd_mode_t  mode_q;
    logic [ADDR_W-1:0]   pc_q;
    logic [ADDR_W-1:0]   fetch_q;
    logic [7:0]          op_q;
    logic                pre_ind_q;
    logic                pre_valid_q;
    logic [7:0]          b1_q;
    logic [7:0]          b2_q;
    logic [2:0]          len_q;
    logic                mem_req_q;
    logic [ADDR_W-1:0]   mem_addr_q;
    logic [ADDR_W-1:0]   ea_q;
    logic [ADDR_W-1:0]   pcn_q;
    logic                ea_valid_q;
    logic                use_sec_q;
    logic                ill_q;
    logic                done_q;

    // =====================================================
    // opcode classification
    amd_pkg::amd_mode_t cur_mode;
    logic               cur_legal;
    logic               is_prefix;
    logic               is_pre_sec;
    logic               is_pre_ind_p;
    logic               is_pre_ind_s;

    // prefixes are compared on the raw bus byte; the latch below decides whether
    // a match is honoured, since only the first byte of an instruction may be one
    assign is_pre_sec   = (mem_rdata == `AMD_PRE_SEC_IDX);
    assign is_pre_ind_p = (mem_rdata == `AMD_PRE_IND_PRI);
    assign is_pre_ind_s = (mem_rdata == `AMD_PRE_IND_SEC);
    assign is_prefix    = is_pre_sec | is_pre_ind_p | is_pre_ind_s;

    // the classifier sees the raw byte, so a second prefix decodes as an opcode;
    // 90 is inherent there, which ends 90 90 as an unsupported pair
    amd_opcode_class u_cls (
        .opcode  (mem_rdata),
        .pre_ind (pre_ind_q),
        .mode    (cur_mode),
        .cls     (),
        .legal   (cur_legal)
    );

    // =====================================================
    // byte counts per mode
    // indirect forms count only the pointer-address byte; the pointer reads that
    // follow are data traffic and are left out of instr_len
    logic [2:0] extra_bytes;
    assign extra_bytes = (cur_mode == amd_pkg::AMD_MODE_INH)  ? 3'h0 :
                         (cur_mode == amd_pkg::AMD_MODE_IX0)  ? 3'h0 :
                         (cur_mode == amd_pkg::AMD_MODE_DIRL) ? `AMD_TWO_BYTES :
                         (cur_mode == amd_pkg::AMD_MODE_IXL)  ? `AMD_TWO_BYTES :
                         `AMD_ONE_BYTE;

    logic       needs_ptr;
    logic       ptr_word;
    assign needs_ptr = (mode_q == amd_pkg::AMD_MODE_INDS) || (mode_q == amd_pkg::AMD_MODE_INDL) ||
                       (mode_q == amd_pkg::AMD_MODE_IIXS) || (mode_q == amd_pkg::AMD_MODE_IIXL) ||
                       (mode_q == amd_pkg::AMD_MODE_RELI);
    assign ptr_word  = (mode_q == amd_pkg::AMD_MODE_INDL) || (mode_q == amd_pkg::AMD_MODE_IIXL);

    // =====================================================
    // effective address datapath
    logic [7:0]        idx_sel;
    logic [ADDR_W-1:0] idx_w;
    logic [ADDR_W-1:0] off_byte_w;
    logic [ADDR_W-1:0] off_word_w;
    logic [ADDR_W-1:0] ea_calc;
    logic [ADDR_W-1:0] rel_w;
    logic              is_rel;

    assign idx_sel    = use_sec_q ? idx_sec : idx_pri;
    // full-width sums so a short offset plus index can exceed page zero
    assign idx_w      = {{(ADDR_W-8){1'b0}}, idx_sel};
    assign off_byte_w = {{(ADDR_W-8){1'b0}}, b1_q};
    assign off_word_w = ADDR_W'({b1_q, b2_q});
    assign is_rel     = (mode_q == amd_pkg::AMD_MODE_RELD) || (mode_q == amd_pkg::AMD_MODE_RELI);
    assign rel_w      = {{(ADDR_W-8){b1_q[7]}}, b1_q};

    // sums wrap at ADDR_W bits; a long offset near the top of memory wraps to
    // page zero rather than flagging an overflow
    always_comb begin
        ea_calc = '0;
        case (mode_q)
            amd_pkg::AMD_MODE_DIRS: ea_calc = off_byte_w;
            amd_pkg::AMD_MODE_DIRL: ea_calc = off_word_w;
            amd_pkg::AMD_MODE_IX0:  ea_calc = idx_w;
            amd_pkg::AMD_MODE_IXS:  ea_calc = idx_w + off_byte_w;
            amd_pkg::AMD_MODE_IXL:  ea_calc = idx_w + off_word_w;
            amd_pkg::AMD_MODE_INDS: ea_calc = off_byte_w;
            amd_pkg::AMD_MODE_INDL: ea_calc = off_word_w;
            amd_pkg::AMD_MODE_IIXS: ea_calc = idx_w + off_byte_w;
            amd_pkg::AMD_MODE_IIXL: ea_calc = idx_w + off_word_w;
            amd_pkg::AMD_MODE_RELD: ea_calc = pc_q + rel_w;
            amd_pkg::AMD_MODE_RELI: ea_calc = pc_q + rel_w;
            default:                ea_calc = '0;
        endcase
    end

    // =====================================================
    // sequencer
    logic rdy;
    assign rdy = clk_en & mem_rvalid;

    // one byte is taken per rvalid pulse; a pulse during a low clk_en is lost
    // and the memory side must offer the byte again
    always_comb begin
        st_d = st_q;
        case (st_q)
            amd_pkg::AMD_ST_IDLE: if (start) st_d = amd_pkg::AMD_ST_OPC;
            amd_pkg::AMD_ST_OPC: begin
                if (rdy) begin
                    // a prefix is only accepted as the first byte
                    if (is_prefix && !pre_valid_q) begin
                        st_d = amd_pkg::AMD_ST_OPC;
                    end else if (!cur_legal && !pre_valid_q) begin
                        st_d = amd_pkg::AMD_ST_ILL;
                    end else if (!cur_legal || is_prefix) begin
                        st_d = amd_pkg::AMD_ST_DONE;
                    end else if (extra_bytes == 3'h0) begin
                        st_d = amd_pkg::AMD_ST_DONE;
                    end else begin
                        st_d = amd_pkg::AMD_ST_OP1;
                    end
                end
            end
            amd_pkg::AMD_ST_OP1: if (rdy) begin
                if (mode_q == amd_pkg::AMD_MODE_DIRL || mode_q == amd_pkg::AMD_MODE_IXL) begin
                    st_d = amd_pkg::AMD_ST_OP2;
                end else if (needs_ptr) begin
                    st_d = amd_pkg::AMD_ST_PTR;
                end else begin
                    st_d = amd_pkg::AMD_ST_DONE;
                end
            end
            amd_pkg::AMD_ST_OP2:  if (rdy) st_d = amd_pkg::AMD_ST_DONE;
            amd_pkg::AMD_ST_PTR:  if (rdy) st_d = ptr_word ? amd_pkg::AMD_ST_PTRL : amd_pkg::AMD_ST_DONE;
            amd_pkg::AMD_ST_PTRL: if (rdy) st_d = amd_pkg::AMD_ST_DONE;
            amd_pkg::AMD_ST_DONE: st_d = amd_pkg::AMD_ST_IDLE;
            amd_pkg::AMD_ST_ILL:  st_d = amd_pkg::AMD_ST_IDLE;
            default:              st_d = amd_pkg::AMD_ST_IDLE;
        endcase
    end

    // =====================================================
    // registers
    logic [ADDR_W-1:0] ptr_base;
    assign ptr_base = {{(ADDR_W-8){1'b0}}, b1_q};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= amd_pkg::AMD_ST_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // the latch clears in both end states, so a prefix never carries over into
    // the next instruction, even after an illegal byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_ind_q   <= 1'b0;
            pre_valid_q <= 1'b0;
            use_sec_q   <= 1'b0;
        end else if (clk_en) begin
            if (st_q == amd_pkg::AMD_ST_OPC && rdy && is_prefix && !pre_valid_q) begin
                pre_valid_q <= 1'b1;
                pre_ind_q   <= is_pre_ind_p | is_pre_ind_s;
                use_sec_q   <= is_pre_sec | is_pre_ind_s;
            end else if (st_q == amd_pkg::AMD_ST_DONE || st_q == amd_pkg::AMD_ST_ILL) begin
                pre_valid_q <= 1'b0;
                pre_ind_q   <= 1'b0;
                use_sec_q   <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_q  <= amd_pkg::AMD_MODE_INH;
            op_q    <= 8'h00;
            b1_q    <= 8'h00;
            b2_q    <= 8'h00;
            len_q   <= 3'h0;
            pc_q    <= '0;
            fetch_q <= '0;
        end else if (clk_en) begin
            case (st_q)
                amd_pkg::AMD_ST_IDLE: if (start) begin
                    fetch_q <= pc_in;
                    len_q   <= 3'h0;
                end
                amd_pkg::AMD_ST_OPC: if (rdy) begin
                    fetch_q <= fetch_q + ADDR_W'(1);
                    len_q   <= len_q + `AMD_ONE_BYTE;
                    op_q    <= mem_rdata;
                    mode_q  <= cur_mode;
                    pc_q    <= fetch_q + ADDR_W'(1);
                end
                amd_pkg::AMD_ST_OP1: if (rdy) begin
                    fetch_q <= fetch_q + ADDR_W'(1);
                    len_q   <= len_q + `AMD_ONE_BYTE;
                    b1_q    <= mem_rdata;
                    pc_q    <= fetch_q + ADDR_W'(1);
                end
                amd_pkg::AMD_ST_OP2: if (rdy) begin
                    len_q <= len_q + `AMD_ONE_BYTE;
                    b2_q  <= mem_rdata;
                    pc_q  <= fetch_q + ADDR_W'(1);
                end
                amd_pkg::AMD_ST_PTR: if (rdy) begin
                    // pointer high byte first for word pointers
                    b1_q <= mem_rdata;
                end
                amd_pkg::AMD_ST_PTRL: if (rdy) begin
                    b2_q <= mem_rdata;
                end
                default: begin
                end
            endcase
        end
    end

    // the low pointer byte sits one above the pointer address; at FF that is 0100,
    // outside page zero, which matches a plain 16-bit increment
    // word pointer: first read lands in b1 (high), second in b2 (low)
    logic [ADDR_W-1:0] ptr_lo_addr;
    assign ptr_lo_addr = ptr_base + ADDR_W'(1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_req_q  <= 1'b0;
            mem_addr_q <= '0;
        end else if (clk_en) begin
            mem_req_q  <= (st_d != amd_pkg::AMD_ST_IDLE) && (st_d != amd_pkg::AMD_ST_DONE) &&
                          (st_d != amd_pkg::AMD_ST_ILL);
            if (st_d == amd_pkg::AMD_ST_PTR && st_q != amd_pkg::AMD_ST_PTR) begin
                mem_addr_q <= {{(ADDR_W-8){1'b0}}, mem_rdata};
            end else if (st_d == amd_pkg::AMD_ST_PTRL && st_q == amd_pkg::AMD_ST_PTR) begin
                mem_addr_q <= ptr_lo_addr;
            end else if (st_q == amd_pkg::AMD_ST_IDLE) begin
                mem_addr_q <= pc_in;
            end else if (rdy) begin
                mem_addr_q <= fetch_q + ADDR_W'(1);
            end
        end
    end

    // relative jumps and immediates have no memory operand: ea_valid stays low for them
    // while ea_addr still carries the relative target
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ea_q       <= '0;
            pcn_q      <= '0;
            ea_valid_q <= 1'b0;
            ill_q      <= 1'b0;
            done_q     <= 1'b0;
        end else if (clk_en) begin
            ea_valid_q <= 1'b0;
            done_q     <= 1'b0;
            ill_q      <= 1'b0;
            if (st_q == amd_pkg::AMD_ST_DONE) begin
                ea_q       <= ea_calc;
                pcn_q      <= pc_q;
                ea_valid_q <= (mode_q != amd_pkg::AMD_MODE_INH) && (mode_q != amd_pkg::AMD_MODE_IMM) && !is_rel;
                done_q     <= 1'b1;
            end
            if (st_q == amd_pkg::AMD_ST_ILL) begin
                ill_q <= 1'b1;
            end
        end
    end

    assign mem_req     = mem_req_q;
    assign mem_addr    = mem_addr_q;
    assign ea_addr     = ea_q;
    assign pc_next     = pcn_q;
    assign ea_valid    = ea_valid_q;
    assign use_sec     = use_sec_q;
    assign opcode_out  = op_q;
    assign instr_len   = len_q;
    assign illegal_rst = ill_q;
    assign done        = done_q;
    // opcode rows in the classifier cover the full group set
endmodule : amd_decoder
`default_nettype wire

// file: bench/amd_decoder_props.sv
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_props #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              mem_rvalid,
    input wire logic              mem_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [ADDR_W-1:0] ea_addr,
    input wire logic              ea_valid,
    input wire logic [2:0]        instr_len,
    input wire logic              illegal_rst,
    input wire logic              done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wait; mem_req && !mem_rvalid; endsequence
    sequence s_ended; ##1 !done && !illegal_rst; endsequence
    property p_hold; s_wait |=> mem_req && $stable(mem_addr); endproperty
    property p_src; done |-> $past(mem_req && mem_rvalid) || $past(mem_req && mem_rvalid, 2); endproperty
    property p_dpulse; done |-> !illegal_rst and s_ended; endproperty
    property p_ipulse; illegal_rst |-> !done ##1 !illegal_rst; endproperty
    property p_ev; ea_valid |-> done; endproperty
    property p_len; done |-> instr_len inside {[3'h1:3'h4]}; endproperty
    property p_ix0; ea_valid && instr_len == 3'h1 |-> ea_addr <= 16'h00FF; endproperty
    property p_ixs; ea_valid && instr_len == 3'h2 |-> ea_addr <= 16'h01FE; endproperty
    // ==========
    // checks
    a_hold: assert property (p_hold) else $error("read request dropped early");
    a_src: assert property (p_src) else $error("done without a byte read");
    a_dpulse: assert property (p_dpulse) else $error("done pulse wrong");
    a_ipulse: assert property (p_ipulse) else $error("reset pulse wrong");
    a_ev: assert property (p_ev) else $error("address valid without done");
    a_len: assert property (p_len) else $error("length out of range");
    a_ix0: assert property (p_ix0) else $error("no offset index off page");
    a_ixs: assert property (p_ixs) else $error("short index beyond 1FE");
endmodule : amd_decoder_props
`default_nettype wire

// file: bench/amd_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module amd_mem_model (
    input wire logic         clk,
    input wire logic         rst_n,
    input wire logic         slow,
    input wire logic         mem_req,
    input wire logic [15:0]  mem_addr,
    output logic [7:0]       mem_rdata,
    output logic             mem_rvalid
);
    logic [7:0] mem [0:65535];
    logic [3:0] lfsr_q;
    // one valid pulse per request; data is inverted in the cycle after a pulse so stale bytes never match
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= 8'hA5;
            lfsr_q <= 4'h9;
        end else begin
            lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
            mem_rvalid <= mem_req && !mem_rvalid && !(slow && lfsr_q[0]);
            mem_rdata <= (mem_req && !mem_rvalid) ? mem[mem_addr] : ~mem_rdata;
        end
    end
endmodule : amd_mem_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk = 0, rst_n = 0, start = 0, slow = 0, mem_req, mem_rvalid, ea_valid, use_sec, illegal_rst, done;
    logic [15:0] pc_in = 0, mem_addr, ea_addr, pc_next;
    logic [7:0]  idx_pri = 0, idx_sec = 0, mem_rdata, opcode_out;
    logic [2:0]  instr_len;
    logic [7:0]  r;
    int          mismatches = 0, compares = 0;
    always #5 clk = ~clk;
    amd_decoder amd_decoder_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .start(start), .pc_in(pc_in),
        .idx_pri(idx_pri), .idx_sec(idx_sec), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
        .mem_req(mem_req), .mem_addr(mem_addr), .ea_addr(ea_addr), .pc_next(pc_next), .ea_valid(ea_valid),
        .use_sec(use_sec), .opcode_out(opcode_out), .instr_len(instr_len), .illegal_rst(illegal_rst), .done(done));
    amd_mem_model amd_mem_model_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task put(input logic [15:0] a, input logic [7:0] v);
        amd_mem_model_inst.mem[a] = v;
    endtask : put
    // full low skips every compare except illegal for codes with no defined result
    task run(input logic [15:0] pc, input logic [31:0] code, input logic [2:0] len, input logic [15:0] ea,
             input logic ev, input logic sec, input logic full, input logic ill = 1'b0);
        int k;
        logic sec_seen;
        sec_seen = 1'b0;
        for (k = 0; k < 4; k++) put(pc + k[15:0], code[31-8*k -: 8]);
        pc_in = pc;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        // the prefix latch clears with done, so the index choice is watched while it stands
        for (k = 0; k < 60 && !done && !illegal_rst; k++) begin
            sec_seen = sec_seen | use_sec;
            @(negedge clk);
        end
        if (k == 60) begin
            mismatches++;
            wrap_up();
        end
        check("illegal", {15'h0, illegal_rst}, {15'h0, ill});
        if (full) begin
            check("ea", ea_addr, ea);
            check("len", {13'h0, instr_len}, {13'h0, len});
            check("next", pc_next, pc + {13'h0, len});
            check("valid", {15'h0, ea_valid}, {15'h0, ev});
            check("sec", {15'h0, sec_seen}, {15'h0, sec});
        end
        @(negedge clk);
    endtask : run
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        void'($urandom(15674));
        idx_pri = 8'h34;
        idx_sec = 8'hC1;
        put(16'h0040, 8'h9A);
        put(16'h0041, 8'hAB);
        put(16'h0042, 8'hCD);
        put(16'h0043, 8'hF0);
        put(16'h0044, 8'h05);
        run(16'h1000, 32'h90F6_0000, 3'h2, 16'h00C1, 1'b1, 1'b1, 1'b1);
        run(16'h1000, 32'hF600_0000, 3'h1, 16'h0034, 1'b1, 1'b0, 1'b1);
        run(16'h1100, 32'hD612_8000, 3'h3, 16'h12B4, 1'b1, 1'b0, 1'b1);
        run(16'h1200, 32'h92B6_4000, 3'h3, 16'h009A, 1'b1, 1'b0, 1'b1);
        run(16'h1300, 32'h92C6_4100, 3'h3, 16'hABCD, 1'b1, 1'b0, 1'b1);
        run(16'h1400, 32'h92E6_4300, 3'h3, 16'h0124, 1'b1, 1'b0, 1'b1);
        run(16'h1500, 32'h91E6_4300, 3'h3, 16'h01B1, 1'b1, 1'b1, 1'b1);
        run(16'h1600, 32'h92D6_4100, 3'h3, 16'hAC01, 1'b1, 1'b0, 1'b1);
        run(16'h2000, 32'h2080_0000, 3'h2, 16'h1F82, 1'b0, 1'b0, 1'b1);
        run(16'h2100, 32'h9220_4400, 3'h3, 16'h2108, 1'b0, 1'b0, 1'b1);
        run(16'h2200, 32'h9090_0000, 3'h2, 16'h0000, 1'b0, 1'b0, 1'b0);
        idx_pri = 8'hFF;
        run(16'h2300, 32'hE6FF_0000, 3'h2, 16'h01FE, 1'b1, 1'b0, 1'b1);
        run(16'h2400, 32'h3100_0000, 3'h1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
        run(16'h2500, 32'h9231_0000, 3'h2, 16'h0000, 1'b0, 1'b0, 1'b0);
        run(16'h2600, 32'hB640_0000, 3'h2, 16'h0040, 1'b1, 1'b0, 1'b1);
        run(16'h2700, 32'hC612_3400, 3'h3, 16'h1234, 1'b1, 1'b0, 1'b1);
        run(16'h2800, 32'h6C10_0000, 3'h2, 16'h010F, 1'b1, 1'b0, 1'b1);
        for (int n = 0; n < 24; n++) begin
            slow = n[0];
            idx_pri = 8'($urandom);
            r = 8'($urandom);
            run(16'h0400 + 16'($urandom % 16'hF000), {8'hE6, r, 16'h0}, 3'h2, {8'h0, idx_pri} + {8'h0, r},
                1'b1, 1'b0, 1'b1);
        end
        wrap_up();
    end
endmodule : testbench
bind amd_decoder amd_decoder_props #(.ADDR_W(ADDR_W)) amd_decoder_props_inst (.clk(clk), .rst_n(rst_n),
    .mem_rvalid(mem_rvalid), .mem_req(mem_req), .mem_addr(mem_addr), .ea_addr(ea_addr), .ea_valid(ea_valid),
    .instr_len(instr_len), .illegal_rst(illegal_rst), .done(done));
`default_nettype wire
